/* rtl/baoa_pkg.sv */
// How it works
// (RULE_01) pc advances by instruction length unless a branch loads a target
// (RULE_02) fetch address is the memory bank joined to the pc
// (RULE_03) relative branch adds displacement to next instruction address
// (RULE_04) displacement is signed, bit 7 sign, sign fills upper bits
// (RULE_05) relative form serves short jump and all conditional branches
// (RULE_06) absolute call and jump copy the 16-bit immediate into the pc
// (RULE_07) fixed-area call target lies within 0800h to 0fffh
// (RULE_08) table index comes from opcode bits 1 to 5
// (RULE_09) vector entries come from table 0040h to 007fh
// (RULE_10) vector low byte at table address, high byte at next address
// (RULE_11) register-indirect jump loads pc from accumulator_pair
// (RULE_12) unsigned_multiply multiplies accumulator by low register into pair
// (RULE_13) unsigned_word_divide uses accumulator_pair as dividend and quotient
// (RULE_14) decimal_adjust_pair corrects the accumulator in place
// (RULE_15) nibble_rotate keeps its digit data in the accumulator
// (RULE_16) register operand uses both bank select flags and the opcode code
// (RULE_17) a 3-bit field picks one of eight byte registers in the bank
// (RULE_18) byte codes 0..7 are x a c b e d l h; pairs ax bc de hl
package baoa_pkg;

  localparam int PC_W      = 16;
  localparam int BANK_W    = 4;
  localparam int LEN_W     = 3;
  localparam int DISP_W    = 8;
  localparam int DISP_SIGN = 7;
  localparam int FAR_W     = 11;
  localparam int TIDX_LO   = 1;
  localparam int TIDX_HI   = 5;
  localparam int RCODE_W   = 3;
  localparam int PCODE_W   = 2;
  localparam int RBANK_W   = 2;

  localparam logic [PC_W-1:0] RESET_PC   = 16'h0000;
  localparam logic [PC_W-1:0] FAR_BASE   = 16'h0800;
  localparam logic [PC_W-1:0] TABLE_BASE = 16'h0040;
  localparam logic [PC_W-1:0] ONE_PC     = 16'h0001;

  // byte register codes
  localparam logic [RCODE_W-1:0] R_X = 3'h0;
  localparam logic [RCODE_W-1:0] R_A = 3'h1;
  localparam logic [RCODE_W-1:0] R_C = 3'h2;
  localparam logic [RCODE_W-1:0] R_B = 3'h3;
  localparam logic [RCODE_W-1:0] R_E = 3'h4;
  localparam logic [RCODE_W-1:0] R_D = 3'h5;
  localparam logic [RCODE_W-1:0] R_L = 3'h6;
  localparam logic [RCODE_W-1:0] R_H = 3'h7;
  // pair codes
  localparam logic [PCODE_W-1:0] RP_AX = 2'h0;
  localparam logic [PCODE_W-1:0] RP_BC = 2'h1;
  localparam logic [PCODE_W-1:0] RP_DE = 2'h2;
  localparam logic [PCODE_W-1:0] RP_HL = 2'h3;

  typedef enum logic [3:0] {
    BAOA_OP_SEQ,
    BAOA_OP_REL,
    BAOA_OP_ABS,
    BAOA_OP_FAR,
    BAOA_OP_TBL,
    BAOA_OP_REGJ
  } baoa_flow_t;

  typedef enum logic [2:0] {
    BAOA_IMP_NONE,
    BAOA_IMP_MUL,
    BAOA_IMP_DIV,
    BAOA_IMP_ADJ,
    BAOA_IMP_ROT
  } baoa_impl_t;

  typedef struct packed {
    baoa_flow_t           flow;
    logic [LEN_W-1:0]     len;
    logic [DISP_W-1:0]    disp;
    logic [PC_W-1:0]      imm16;
    logic [FAR_W-1:0]     far;
    logic [7:0]           opcode;
  } baoa_instr_t;

  typedef struct packed {
    logic                 req;
    logic [PC_W-1:0]      addr;
  } baoa_mem_req_t;

  typedef struct packed {
    logic                 byte_en;
    logic [RBANK_W-1:0]   bank;
    logic [RCODE_W-1:0]   code;
    logic                 pair_en;
    logic [PCODE_W-1:0]   pcode;
  } baoa_reg_sel_t;

endpackage : baoa_pkg

/* rtl/baoa_opsel.sv */
`timescale 1ns/1ps
module baoa_opsel
  import baoa_pkg::*;
(
  // selection controls
  input  wire logic               i_rbs_low,
  input  wire logic               i_rbs_high,
  input  wire logic [RCODE_W-1:0] i_rcode,
  input  wire logic [PCODE_W-1:0] i_pcode,
  input  wire logic               i_byte_op,
  input  wire logic               i_pair_op,
  input  wire baoa_impl_t         i_impl,
  // resolved selection
  output baoa_reg_sel_t           o_sel
);

  wire logic [RBANK_W-1:0] bank = {i_rbs_high, i_rbs_low}; // [RULE_16]
  wire logic imp_pair = (i_impl == BAOA_IMP_MUL)
                     || (i_impl == BAOA_IMP_DIV); // [RULE_12] [RULE_13]
  wire logic imp_acc = (i_impl != BAOA_IMP_NONE)
                    && (i_impl != BAOA_IMP_DIV); // [RULE_14] [RULE_15]
  // mul reads a with x as the low operand, writes ax
  wire logic [RCODE_W-1:0] code =
    (i_impl == BAOA_IMP_MUL) ? R_X :
    imp_acc                  ? R_A : i_rcode; // [RULE_17] [RULE_18]

  assign o_sel.bank    = bank;
  assign o_sel.code    = code;
  assign o_sel.byte_en = i_byte_op || imp_acc;
  assign o_sel.pair_en = i_pair_op || imp_pair;
  assign o_sel.pcode   = imp_pair ? RP_AX : i_pcode; // [RULE_18]

endmodule : baoa_opsel

/* rtl/baoa_core.sv */
`timescale 1ns/1ps
module baoa_core
  import baoa_pkg::*;
(
  // clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst_b,
  input  wire logic               i_ce,
  // decoded instruction
  input  wire logic               i_exec,
  input  wire baoa_instr_t        i_instr,
  input  wire logic [PC_W-1:0]    i_acc_pair,
  input  wire logic [BANK_W-1:0]  i_mem_bank,
  // vector data from program memory
  input  wire logic               i_vec_valid,
  input  wire logic [7:0]         i_vec_data,
  // operand selection inputs
  input  wire logic               i_rbs_low,
  input  wire logic               i_rbs_high,
  input  wire logic [RCODE_W-1:0] i_rcode,
  input  wire logic [PCODE_W-1:0] i_pcode,
  input  wire logic               i_byte_op,
  input  wire logic               i_pair_op,
  input  wire baoa_impl_t         i_impl,
  // outputs
  output logic [PC_W-1:0]         o_pc,
  output logic [BANK_W+PC_W-1:0]  o_fetch_addr,
  output baoa_mem_req_t           o_vec_req,
  output logic                    o_busy,
  output baoa_reg_sel_t           o_reg_sel
);

  typedef enum logic [1:0] {BAOA_RUN, BAOA_VLO, BAOA_VHI} baoa_state_t;

  baoa_state_t          state_q, state_d;
  logic [PC_W-1:0]      pc_q, pc_d;
  logic [7:0]           vlo_q;
  logic [PC_W-1:0]      taddr_q;
  baoa_reg_sel_t        sel_w;

  ////////////////////////////////////////////////////////////////////////
  // target generation
  wire logic [PC_W-1:0] next_seq =
    pc_q + PC_W'(i_instr.len); // [RULE_01]
  wire logic [PC_W-1:0] disp_ext =
    {{(PC_W-DISP_W){i_instr.disp[DISP_SIGN]}}, i_instr.disp}; // [RULE_04]
  wire logic [PC_W-1:0] rel_tgt = next_seq + disp_ext; // [RULE_03] [RULE_05]
  wire logic [PC_W-1:0] far_tgt =
    FAR_BASE | PC_W'(i_instr.far); // [RULE_07]
  wire logic [PC_W-1:0] tbl_addr =
    TABLE_BASE
    | PC_W'({i_instr.opcode[TIDX_HI:TIDX_LO], 1'b0}); // [RULE_08] [RULE_09]
  wire logic run_exec = i_exec && (state_q == BAOA_RUN);

  always_comb begin
    pc_d    = pc_q;
    state_d = state_q;
    case (state_q)
      BAOA_RUN: begin
        if (i_exec) begin
          case (i_instr.flow)
            BAOA_OP_SEQ:  pc_d = next_seq; // [RULE_01]
            BAOA_OP_REL:  pc_d = rel_tgt; // [RULE_03]
            BAOA_OP_ABS:  pc_d = i_instr.imm16; // [RULE_06]
            BAOA_OP_FAR:  pc_d = far_tgt; // [RULE_07]
            BAOA_OP_REGJ: pc_d = i_acc_pair; // [RULE_11]
            BAOA_OP_TBL:  state_d = BAOA_VLO;
            default:      pc_d = next_seq;
          endcase
        end
      end
      BAOA_VLO: begin
        if (i_vec_valid) begin
          state_d = BAOA_VHI;
        end
      end
      BAOA_VHI: begin
        if (i_vec_valid) begin
          pc_d    = {i_vec_data, vlo_q}; // [RULE_10]
          state_d = BAOA_RUN;
        end
      end
      default: state_d = BAOA_RUN;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= BAOA_RUN;
      pc_q    <= RESET_PC;
      vlo_q   <= '0;
      taddr_q <= '0;
    end else if (i_ce) begin
      state_q <= state_d;
      pc_q    <= pc_d;
      if (run_exec && i_instr.flow == BAOA_OP_TBL) begin
        taddr_q <= tbl_addr;
      end
      if (state_q == BAOA_VLO && i_vec_valid) begin
        vlo_q <= i_vec_data; // [RULE_10]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  wire logic vec_phase = (state_d == BAOA_VLO) || (state_d == BAOA_VHI);
  wire logic [PC_W-1:0] vec_addr_d =
    (state_d == BAOA_VHI) ? ((state_q == BAOA_VHI) ? taddr_q + ONE_PC
                                                    : taddr_q + ONE_PC)
                          : ((state_q == BAOA_RUN) ? tbl_addr : taddr_q);

  baoa_opsel u_opsel (
    .i_rbs_low  (i_rbs_low),
    .i_rbs_high (i_rbs_high),
    .i_rcode    (i_rcode),
    .i_pcode    (i_pcode),
    .i_byte_op  (i_byte_op),
    .i_pair_op  (i_pair_op),
    .i_impl     (i_impl),
    .o_sel      (sel_w)
  );

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pc         <= RESET_PC;
      o_fetch_addr <= '0;
      o_vec_req    <= '0;
      o_busy       <= 1'b0;
      o_reg_sel    <= '0;
    end else if (i_ce) begin
      o_pc           <= pc_d;
      o_fetch_addr   <= {i_mem_bank, pc_d}; // [RULE_02]
      o_vec_req.req  <= vec_phase; // [RULE_09]
      o_vec_req.addr <= vec_phase ? vec_addr_d : '0;
      o_busy         <= vec_phase;
      o_reg_sel      <= sel_w; // [RULE_16]
    end
  end

endmodule : baoa_core

/* tb/baoa_core_assertions.sv */
`timescale 1ns/1ps
module baoa_core_checker
  import baoa_pkg::*;
(
  // clock, reset and inputs
  input wire logic                   i_clk,
  input wire logic                   i_rst_b,
  input wire logic                   i_ce,
  input wire logic                   i_exec,
  input wire baoa_instr_t            i_instr,
  input wire logic [PC_W-1:0]        i_acc_pair,
  input wire logic [BANK_W-1:0]      i_mem_bank,
  input wire logic                   i_vec_valid,
  input wire logic [7:0]             i_vec_data,
  // outputs
  input wire logic [PC_W-1:0]        o_pc,
  input wire logic [BANK_W+PC_W-1:0] o_fetch_addr,
  input wire baoa_mem_req_t          o_vec_req,
  input wire logic                   o_busy
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  wire go = i_ce & i_exec & ~o_busy;
  wire [15:0] seq_t = o_pc + 16'(i_instr.len);
  wire [15:0] rel_t = seq_t + {{8{i_instr.disp[7]}}, i_instr.disp};
  wire [15:0] tbl_a = TABLE_BASE | 16'({i_instr.opcode[5:1], 1'b0});
  wire is_seq = i_instr.flow == BAOA_OP_SEQ;
  wire is_rel = i_instr.flow == BAOA_OP_REL;
  wire is_abs = i_instr.flow == BAOA_OP_ABS;
  wire is_far = i_instr.flow == BAOA_OP_FAR;
  wire is_tbl = i_instr.flow == BAOA_OP_TBL;
  wire is_rgj = i_instr.flow == BAOA_OP_REGJ;
  // byte steps only count while the clock enable lets state move
  sequence lo_byte;
    i_ce && o_busy && i_vec_valid && !o_vec_req.addr[0];
  endsequence
  sequence hi_byte;
    i_ce && o_busy && i_vec_valid && o_vec_req.addr[0];
  endsequence
  a_seq_advance: assert property (go && is_seq
    |=> o_pc == $past(seq_t)) else $error("pc step wrong");
  a_busy_hold: assert property (o_busy && !i_vec_valid
    |=> $stable(o_pc)) else $error("pc moved while busy");
  a_fetch_pc: assert property (o_fetch_addr[15:0] == o_pc)
    else $error("fetch address low part differs from pc");
  a_fetch_bank: assert property (i_ce
    |=> o_fetch_addr[19:16] == $past(i_mem_bank))
    else $error("fetch bank wrong");
  a_rel_target: assert property (go && is_rel
    |=> o_pc == $past(rel_t)) else $error("relative target wrong");
  a_abs_target: assert property (go && is_abs
    |=> o_pc == $past(i_instr.imm16)) else $error("absolute target wrong");
  a_far_area: assert property (go && is_far
    |=> o_pc[15:11] == 5'h01 && o_pc[10:0] == $past(i_instr.far))
    else $error("fixed area target wrong");
  a_tbl_start: assert property (go && is_tbl
    |=> o_busy && o_vec_req.req && o_vec_req.addr == $past(tbl_a))
    else $error("table request wrong");
  a_vec_pair: assert property (lo_byte
    |=> o_vec_req.addr == $past(o_vec_req.addr) + 16'h0001)
    else $error("high byte address wrong");
  a_vec_load: assert property (hi_byte
    |=> !o_busy && o_pc[15:8] == $past(i_vec_data))
    else $error("vector load wrong");
  a_regj_target: assert property (go && is_rgj
    |=> o_pc == $past(i_acc_pair)) else $error("register jump wrong");
endmodule : baoa_core_checker

bind baoa_core baoa_core_checker i_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_ce(i_ce), .i_exec(i_exec), .i_instr(i_instr), .i_acc_pair(i_acc_pair),
  .i_mem_bank(i_mem_bank),
  .i_vec_valid(i_vec_valid), .i_vec_data(i_vec_data), .o_pc(o_pc),
  .o_fetch_addr(o_fetch_addr), .o_vec_req(o_vec_req), .o_busy(o_busy));

/* tb/baoa_prog_mem.sv */
`timescale 1ns/1ps
module baoa_prog_mem
  import baoa_pkg::*;
(
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_b,
  // table read
  input  wire baoa_mem_req_t i_req,
  input  wire logic [3:0]    i_dly,
  output logic               o_valid,
  output logic [7:0]         o_data
);
  logic [3:0] cnt_q;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q   <= 4'h0;
      o_valid <= 1'b0;
      o_data  <= 8'h00;
    end else if (i_req.req && !o_valid && cnt_q >= i_dly) begin
      o_valid <= 1'b1;
      o_data  <= i_req.addr[7:0] ^ 8'ha5;
      cnt_q   <= 4'h0;
    end else begin
      // data line shows junk once the byte is taken
      o_valid <= 1'b0;
      o_data  <= ~o_data;
      cnt_q   <= i_req.req ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule : baoa_prog_mem

/* tb/baoa_core_tb.sv */
`timescale 1ns/1ps
module baoa_core_tb
  import baoa_pkg::*;
;
  typedef struct packed {
    baoa_flow_t f;
    logic [2:0] len;
    logic [7:0] d;
    logic [15:0] v;
    logic [15:0] pc;
  } baoa_row_t;
  baoa_row_t rows [8] = '{
    '{BAOA_OP_SEQ, 3'h3, 8'h00, 16'h0000, 16'h0003},
    '{BAOA_OP_REL, 3'h2, 8'h80, 16'h0000, 16'hff85},
    '{BAOA_OP_REL, 3'h2, 8'h7f, 16'h0000, 16'h0006},
    '{BAOA_OP_ABS, 3'h3, 8'h00, 16'h1234, 16'h1234},
    '{BAOA_OP_FAR, 3'h2, 8'h00, 16'hffff, 16'h0fff},
    '{BAOA_OP_REGJ, 3'h1, 8'h00, 16'hbeef, 16'hbeef},
    '{BAOA_OP_SEQ, 3'h1, 8'h00, 16'h0000, 16'hbef0},
    '{BAOA_OP_FAR, 3'h2, 8'h00, 16'h0000, 16'h0800}};
  logic          clk, rst_b, ce, exec, vv, rbs_l, rbs_h, bop, pop, busy;
  logic [7:0]    vd;
  logic [3:0]    bank, dly;
  logic [2:0]    rcode;
  logic [1:0]    pcode;
  logic [15:0]   acc, pc;
  logic [19:0]   fa;
  baoa_instr_t   instr;
  baoa_impl_t    impl;
  baoa_mem_req_t vreq;
  baoa_reg_sel_t rsel;
  int            fails = 0;
  int            samples_checked = 0;
  baoa_core i_dut (.i_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_exec(exec),
    .i_instr(instr), .i_acc_pair(acc), .i_mem_bank(bank), .i_vec_valid(vv),
    .i_vec_data(vd), .i_rbs_low(rbs_l), .i_rbs_high(rbs_h), .i_rcode(rcode),
    .i_pcode(pcode), .i_byte_op(bop), .i_pair_op(pop), .i_impl(impl),
    .o_pc(pc), .o_fetch_addr(fa), .o_vec_req(vreq), .o_busy(busy),
    .o_reg_sel(rsel));
  baoa_prog_mem i_mem (.i_clk(clk), .i_rst_b(rst_b), .i_req(vreq),
    .i_dly(dly), .o_valid(vv), .o_data(vd));
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic tbl(input logic [4:0] idx, input logic [3:0] d,
                     input logic [15:0] e);
    int n;
    dly = d;
    instr.flow = BAOA_OP_TBL;
    instr.opcode = {2'b11, idx, 1'b1};
    exec = 1'b1;
    @(negedge clk);
    chk(vreq.addr, 16'h0040 | {idx, 1'b0});
    // next instruction waits behind the vector fetch
    instr.flow = BAOA_OP_SEQ;
    instr.len = 3'h1;
    for (n = 0; n < 40 && busy !== 1'b0; n++) @(negedge clk);
    if (n == 40) begin
      fails++;
      conclude();
    end
    chk(pc, e);
    @(negedge clk);
    exec = 1'b0;
    chk(pc, e + 16'h0001);
  endtask : tbl
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {rst_b, exec, rbs_l, rbs_h, bop, pop, rcode, pcode} = '0;
    {ce, instr, acc, bank, dly, impl} = {1'b1, 74'h0, BAOA_IMP_NONE};
    repeat (16) @(negedge clk);
    chk({busy, pc}, 17'h0_0000);
    rst_b = 1'b1;
    for (int i = 0; i < 8; i++) begin
      {instr.flow, instr.len, instr.disp} = {rows[i].f, rows[i].len, rows[i].d};
      {instr.imm16, instr.far, acc} = {rows[i].v, rows[i].v[10:0], rows[i].v};
      bank = 4'(i + 9);
      exec = 1'b1;
      @(negedge clk);
      chk(pc, rows[i].pc);
      chk(fa, {bank, rows[i].pc});
    end
    {instr.flow, instr.len, ce} = {BAOA_OP_SEQ, 3'h1, 1'b0};
    @(negedge clk);
    chk(pc, 16'h0800);
    ce = 1'b1;
    tbl(5'h1f, 4'h0, 16'hdadb);
    tbl(5'h00, 4'h3, 16'he4e5);
    for (int k = 0; k < 8; k++) begin
      {rcode, pcode, rbs_h, rbs_l, bop, pop} = {3'(k), 2'(k), 2'(k), 2'b11};
      @(negedge clk);
      chk({rsel.code, rsel.bank, rsel.pcode}, {3'(k), 2'(k), 2'(k)});
      chk({rsel.byte_en, rsel.pair_en}, 2'b11);
    end
    {rcode, pcode, impl} = {R_H, RP_HL, BAOA_IMP_MUL};
    @(negedge clk);
    chk({rsel.code, rsel.pcode}, {R_X, RP_AX});
    impl = BAOA_IMP_DIV;
    @(negedge clk);
    chk(rsel.pcode, RP_AX);
    impl = BAOA_IMP_ADJ;
    @(negedge clk);
    chk(rsel.code, R_A);
    impl = BAOA_IMP_ROT;
    @(negedge clk);
    chk(rsel.code, R_A);
    rst_b = 1'b0;
    @(negedge clk);
    chk({busy, pc}, 17'h0_0000);
    conclude();
  end
endmodule : baoa_core_tb
